/* verilog/psm_pkg.sv */
// Package of command codes, field positions, reset values and limits for the phase shedding monitor
package psm_pkg;

   // ************************************************************
   // Command codes of the host register port
   // ************************************************************
   localparam logic [7:0] CMD_OVERTEMP_WARN_LIMIT  = 8'h50;
   localparam logic [7:0] CMD_OVERTEMP_FAULT_LIMIT = 8'h51;
   localparam logic [7:0] CMD_READ_INPUT_VOLTAGE   = 8'h88;
   localparam logic [7:0] CMD_READ_TEMPERATURE     = 8'h8d;
   localparam logic [7:0] CMD_READ_ENABLE_VOLTAGE  = 8'hd8;
   localparam logic [7:0] CMD_READ_SENSE_TWO       = 8'hd9;
   localparam logic [7:0] CMD_READ_STATUS          = 8'hda;
   localparam logic [7:0] CMD_MANUFACTURER_CONFIG  = 8'hd1;
   localparam logic [7:0] CMD_POWER_GOOD_LIMITS    = 8'he0;
   localparam logic [7:0] CMD_THERMISTOR_GAIN      = 8'hf7;
   localparam logic [7:0] CMD_THERMISTOR_OFFSET    = 8'hf8;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int LP_PHASES_MSB = 7;
   localparam int LP_PHASES_LSB = 6;
   localparam int PG_HIGH_MSB   = 1;
   localparam int PG_HIGH_LSB   = 0;

   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [7:0] RST_MANUFACTURER_CONFIG  = 8'h00;
   localparam logic [7:0] RST_POWER_GOOD_LIMITS    = 8'h00;
   localparam logic [7:0] RST_OVERTEMP_WARN_LIMIT  = 8'hff;
   localparam logic [7:0] RST_OVERTEMP_FAULT_LIMIT = 8'hff;
   localparam logic [7:0] RST_THERMISTOR_GAIN      = 8'h01;
   localparam logic [7:0] RST_THERMISTOR_OFFSET    = 8'h00;

   // ************************************************************
   // Analog limits in millivolts and the input divider shift
   // ************************************************************
   localparam logic [11:0] PG_HIGH_MV_00    = 12'd300;
   localparam logic [11:0] PG_HIGH_MV_01    = 12'd250;
   localparam logic [11:0] PG_HIGH_MV_10    = 12'd200;
   localparam logic [11:0] PG_HIGH_MV_11    = 12'd150;
   localparam logic [11:0] CROWBAR_RELEASE_MV = 12'd300;
   localparam int          VIN_DIVIDER_SHIFT = 3;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      PSM_OFF   = 2'b00,
      PSM_START = 2'b01,
      PSM_RUN   = 2'b10
   } psm_state_t;

endpackage

/* verilog/psm_sync.sv */
// Three stage input synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module psm_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_value,
   output logic      [WIDTH-1:0] sync_out
);
   import psm_pkg::*;

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] out_next;

   // Refuse an empty synchroniser while the design is built
   if (WIDTH < 1) $error("psm_sync WIDTH must be at least 1");

   // Output follows only bits whose last two stages agree
   always_comb begin
      out_next = out_reg;
      for (int i = 0; i < WIDTH; i++) begin
         if (stage2_reg[i] == stage3_reg[i]) out_next[i] = stage3_reg[i];
      end
   end

   // Shift chain; stages clear on reset, so output starts at reset_value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         out_reg    <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         out_reg    <= out_next;
      end
   end

   assign sync_out = out_reg ^ reset_value;
endmodule

/* verilog/psm_temp.sv */
// Thermistor temperature computation: voltage times gain plus offset, saturated
`timescale 1ns/1ps
module psm_temp #(
   parameter int ADC_BITS = 10,
   parameter int OUT_BITS = 16
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [ADC_BITS-1:0] therm_code,
   input  wire logic [7:0]          gain,
   input  wire logic [7:0]          offset,
   output logic      [OUT_BITS-1:0] temperature
);
   import psm_pkg::*;

   localparam int FULL_BITS = ADC_BITS + 9;

   logic [FULL_BITS-1:0] full_sum;
   logic [OUT_BITS-1:0]  temp_reg;
   logic [OUT_BITS-1:0]  temp_next;

   // Refuse an output word that cannot hold the raw code or exceeds the sum
   if (OUT_BITS < ADC_BITS || OUT_BITS > FULL_BITS) $error("psm_temp OUT_BITS out of range");

   // Gain 1 with offset 0 returns the raw pin code unchanged
   always_comb begin
      full_sum  = FULL_BITS'(therm_code) * FULL_BITS'(gain) + FULL_BITS'(offset);
      temp_next = full_sum[OUT_BITS-1:0];
      if (full_sum > FULL_BITS'({OUT_BITS{1'b1}})) temp_next = {OUT_BITS{1'b1}};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) temp_reg <= '0;
      else     temp_reg <= temp_next;
   end

   assign temperature = temp_reg;
endmodule

/* verilog/psm_top.sv */
// Phase shedding, enable gating, crowbar, thermal and voltage monitor control logic
//
// Operation
// - Low-power input low drives the shed phase disable output low.
// - After reset only phase 1 runs during low-power until software changes it.
// - Low-power phase code sits in bits 7:6 of manufacturer config, host writable.
// - Six phases: 00 and 11 run 1; 01 runs 1,4; 10 runs 1,3,5.
// - Four phases: code 01 runs phases 1 and 3; others run phase 1.
// - Five phases: 01 runs 1 and 4; three or fewer always run phase 1.
// - Lockout or low enable holds PWM, power good and both disables low.
// - Startup begins only when supply above lockout and enable above threshold together.
// - Over crowbar level PWM held low until output drops below 300 mV.
// - Crowbar level follows the programmed power good high limit.
// - Overtemperature indicator asserts when temperature exceeds the fault limit.
// - Temperature equals thermistor voltage times gain plus offset.
// - Gain 1 and offset 0 returns the raw thermistor voltage.
// - Warning and fault limits host programmable; temperature readable by host.
// - Enable and two sense voltages measured 10 bits wide; enable and second sense readable, first only as input voltage.
// - Input voltage reading is first sense voltage times eight.
// - Power good high limit code bits 1:0: 300, 250, 200, 150 mV.
`timescale 1ns/1ps
module psm_top #(
   parameter int PHASES   = 6,
   parameter int ADC_BITS = 10
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                low_power_state_input_n,
   input  wire logic                enable_above_threshold,
   input  wire logic                undervoltage_lockout,
   input  wire logic [2:0]          normal_phase_count,
   input  wire logic [PHASES-1:0]   pwm_in,
   input  wire logic                power_good_in,
   input  wire logic [11:0]         vout_mv,
   input  wire logic [11:0]         vid_mv,
   input  wire logic [ADC_BITS-1:0] thermistor_sense_code,
   input  wire logic [ADC_BITS-1:0] enable_pin_code,
   input  wire logic [ADC_BITS-1:0] voltage_sense_one_code,
   input  wire logic [ADC_BITS-1:0] voltage_sense_two_code,
   input  wire logic                reg_wr_en,
   input  wire logic                reg_rd_en,
   input  wire logic [7:0]          reg_cmd,
   input  wire logic [7:0]          reg_wdata,
   output logic      [15:0]         reg_rdata,
   output logic                     reg_rd_valid,
   output logic                     reg_cmd_error,
   output logic      [PHASES-1:0]   pwm_out,
   output logic      [PHASES-1:0]   low_power_phase_mask,
   output logic                     shed_phase_disable_n,
   output logic                     main_phase_disable_n,
   output logic                     power_good,
   output logic                     startup_begin,
   output logic                     crowbar_active,
   output logic                     overtemp_indicator,
   output logic                     overtemp_warning
);
   import psm_pkg::*;

   // The mapping table and read words serve six phases and ten bit codes only
   if (PHASES != 6) $error("psm_top PHASES must be 6");
   if (ADC_BITS != 10) $error("psm_top ADC_BITS must be 10");


   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [1:0] pins_sync;
   logic       low_power_active;
   logic       enable_ok;
   logic       lockout_sync;

   // Low-power input rests high, so it is inverted before the synchroniser
   psm_sync #(
      .WIDTH       (3)
   ) u_pin_sync (
      .clk         (clk),
      .rst         (rst),
      .async_in    ({undervoltage_lockout, enable_above_threshold, ~low_power_state_input_n}),
      .reset_value (3'b000),
      .sync_out    ({lockout_sync, pins_sync})
   );

   assign low_power_active = pins_sync[0];
   assign enable_ok        = pins_sync[1];

   // ************************************************************
   // Host registers
   // ************************************************************
   logic [7:0]  manufacturer_config_reg;
   logic [7:0]  manufacturer_config_next;
   logic [7:0]  pg_limits_reg;
   logic [7:0]  pg_limits_next;
   logic [7:0]  ot_warn_limit_reg;
   logic [7:0]  ot_warn_limit_next;
   logic [7:0]  overtemp_fault_limit_reg;
   logic [7:0]  overtemp_fault_limit_next;
   logic [7:0]  therm_gain_reg;
   logic [7:0]  therm_gain_next;
   logic [7:0]  therm_offset_reg;
   logic [7:0]  therm_offset_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        rd_valid_reg;
   logic        rd_valid_next;
   logic        cmd_error_reg;
   logic        cmd_error_next;

   logic [15:0] temperature_reading;
   logic [12:0] input_voltage_reading;
   logic [ADC_BITS-1:0] enable_reading_reg;
   logic [ADC_BITS-1:0] sense_two_reading_reg;
   logic [12:0] input_voltage_reg;
   logic [7:0]  status_byte;

   // Write decode and read mux; unknown commands raise the error pulse
   always_comb begin
      manufacturer_config_next     = manufacturer_config_reg;
      pg_limits_next      = pg_limits_reg;
      ot_warn_limit_next  = ot_warn_limit_reg;
      overtemp_fault_limit_next = overtemp_fault_limit_reg;
      therm_gain_next     = therm_gain_reg;
      therm_offset_next   = therm_offset_reg;
      rdata_next          = rdata_reg;
      rd_valid_next       = 1'b0;
      cmd_error_next      = 1'b0;
      if (reg_wr_en) begin
         case (reg_cmd)
            CMD_MANUFACTURER_CONFIG:  manufacturer_config_next     = reg_wdata;
            CMD_POWER_GOOD_LIMITS:    pg_limits_next      = reg_wdata;
            CMD_OVERTEMP_WARN_LIMIT:  ot_warn_limit_next  = reg_wdata;
            CMD_OVERTEMP_FAULT_LIMIT: overtemp_fault_limit_next = reg_wdata;
            CMD_THERMISTOR_GAIN:      therm_gain_next     = reg_wdata;
            CMD_THERMISTOR_OFFSET:    therm_offset_next   = reg_wdata;
            default:                  cmd_error_next      = 1'b1;
         endcase
      end else if (reg_rd_en) begin
         rd_valid_next = 1'b1;
         case (reg_cmd)
            CMD_MANUFACTURER_CONFIG:  rdata_next = {8'h00, manufacturer_config_reg};
            CMD_POWER_GOOD_LIMITS:    rdata_next = {8'h00, pg_limits_reg};
            CMD_OVERTEMP_WARN_LIMIT:  rdata_next = {8'h00, ot_warn_limit_reg};
            CMD_OVERTEMP_FAULT_LIMIT: rdata_next = {8'h00, overtemp_fault_limit_reg};
            CMD_THERMISTOR_GAIN:      rdata_next = {8'h00, therm_gain_reg};
            CMD_THERMISTOR_OFFSET:    rdata_next = {8'h00, therm_offset_reg};
            CMD_READ_TEMPERATURE:     rdata_next = temperature_reading;
            CMD_READ_INPUT_VOLTAGE:   rdata_next = {3'h0, input_voltage_reg};
            CMD_READ_ENABLE_VOLTAGE:  rdata_next = {6'h00, enable_reading_reg};
            CMD_READ_SENSE_TWO:       rdata_next = {6'h00, sense_two_reading_reg};
            CMD_READ_STATUS:          rdata_next = {8'h00, status_byte};
            default: begin
               rdata_next     = 16'h0000;
               cmd_error_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         manufacturer_config_reg     <= RST_MANUFACTURER_CONFIG;
         pg_limits_reg      <= RST_POWER_GOOD_LIMITS;
         ot_warn_limit_reg  <= RST_OVERTEMP_WARN_LIMIT;
         overtemp_fault_limit_reg <= RST_OVERTEMP_FAULT_LIMIT;
         therm_gain_reg     <= RST_THERMISTOR_GAIN;
         therm_offset_reg   <= RST_THERMISTOR_OFFSET;
         rdata_reg          <= 16'h0000;
         rd_valid_reg       <= 1'b0;
         cmd_error_reg      <= 1'b0;
      end else begin
         manufacturer_config_reg     <= manufacturer_config_next;
         pg_limits_reg      <= pg_limits_next;
         ot_warn_limit_reg  <= ot_warn_limit_next;
         overtemp_fault_limit_reg <= overtemp_fault_limit_next;
         therm_gain_reg     <= therm_gain_next;
         therm_offset_reg   <= therm_offset_next;
         rdata_reg          <= rdata_next;
         rd_valid_reg       <= rd_valid_next;
         cmd_error_reg      <= cmd_error_next;
      end
   end

   assign reg_rdata     = rdata_reg;
   assign reg_rd_valid  = rd_valid_reg;
   assign reg_cmd_error = cmd_error_reg;

   // ************************************************************
   // Voltage and temperature monitoring
   // ************************************************************
   psm_temp #(
      .ADC_BITS    (ADC_BITS),
      .OUT_BITS    (16)
   ) u_temp (
      .clk         (clk),
      .rst         (rst),
      .therm_code  (thermistor_sense_code),
      .gain        (therm_gain_reg),
      .offset      (therm_offset_reg),
      .temperature (temperature_reading)
   );

   // Divide-by-eight network assumed on the first sense pin
   assign input_voltage_reading = {voltage_sense_one_code, 3'b000};

   logic ot_fault_next;
   logic ot_fault_reg;
   logic ot_warn_next;
   logic ot_warn_reg;

   // Limit comparisons against the full temperature word
   always_comb begin
      ot_fault_next = temperature_reading > {8'h00, overtemp_fault_limit_reg};
      ot_warn_next  = temperature_reading > {8'h00, ot_warn_limit_reg};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ot_fault_reg          <= 1'b0;
         ot_warn_reg           <= 1'b0;
         enable_reading_reg    <= '0;
         sense_two_reading_reg <= '0;
         input_voltage_reg     <= '0;
      end else begin
         ot_fault_reg          <= ot_fault_next;
         ot_warn_reg           <= ot_warn_next;
         enable_reading_reg    <= enable_pin_code;
         sense_two_reading_reg <= voltage_sense_two_code;
         input_voltage_reg     <= input_voltage_reading;
      end
   end

   assign overtemp_indicator = ot_fault_reg;
   assign overtemp_warning   = ot_warn_reg;

   // ************************************************************
   // Low-power phase selection
   // ************************************************************
   logic [1:0]        lp_code;
   logic [PHASES-1:0] lp_mask;

   assign lp_code = manufacturer_config_reg[LP_PHASES_MSB:LP_PHASES_LSB];

   // Mapping row picked by the strapped normal phase count
   always_comb begin
      lp_mask = 6'h01;
      case (normal_phase_count)
         3'h6: begin
            if (lp_code == 2'b01)      lp_mask = 6'h09;
            else if (lp_code == 2'b10) lp_mask = 6'h15;
         end
         3'h5: begin
            if (lp_code == 2'b01)      lp_mask = 6'h09;
         end
         3'h4: begin
            if (lp_code == 2'b01)      lp_mask = 6'h05;
         end
         default: lp_mask = 6'h01;
      endcase
   end

   assign low_power_phase_mask = lp_mask;

   // ************************************************************
   // Enable sequencing and crowbar
   // ************************************************************
   psm_state_t  state_reg;
   psm_state_t  state_next;
   logic        crowbar_reg;
   logic        crowbar_next;
   logic [11:0] pg_high_mv;
   logic [12:0] crowbar_level;
   logic        enabled;

   // Crowbar level tracks the power good high limit code
   always_comb begin
      case (pg_limits_reg[PG_HIGH_MSB:PG_HIGH_LSB])
         2'b00:   pg_high_mv = PG_HIGH_MV_00;
         2'b01:   pg_high_mv = PG_HIGH_MV_01;
         2'b10:   pg_high_mv = PG_HIGH_MV_10;
         default: pg_high_mv = PG_HIGH_MV_11;
      endcase
      crowbar_level = {1'b0, vid_mv} + {1'b0, pg_high_mv};
   end

   // Start only when both lockout clear and enable high in one cycle
   always_comb begin
      state_next   = state_reg;
      crowbar_next = crowbar_reg;
      case (state_reg)
         PSM_OFF: begin
            if (!lockout_sync && enable_ok) state_next = PSM_START;
         end
         PSM_START: state_next = PSM_RUN;
         PSM_RUN:   state_next = PSM_RUN;
         default:   state_next = PSM_OFF;
      endcase
      if (lockout_sync || !enable_ok) state_next = PSM_OFF;
      if ({1'b0, vout_mv} > crowbar_level) crowbar_next = 1'b1;
      else if (vout_mv < CROWBAR_RELEASE_MV) crowbar_next = 1'b0;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg   <= PSM_OFF;
         crowbar_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         crowbar_reg <= crowbar_next;
      end
   end

   assign enabled        = (state_reg != PSM_OFF);
   assign startup_begin  = (state_reg == PSM_START);
   assign crowbar_active = crowbar_reg;

   // ************************************************************
   // Output gating
   // ************************************************************
   logic [PHASES-1:0] pwm_next;
   logic [PHASES-1:0] pwm_reg;
   logic              shed_n_next;
   logic              shed_n_reg;
   logic              main_n_next;
   logic              main_n_reg;
   logic              pg_next;
   logic              pg_reg;

   // PWM low when off or crowbarred; shed phases masked in low power
   always_comb begin
      pwm_next    = '0;
      shed_n_next = 1'b0;
      main_n_next = 1'b0;
      pg_next     = 1'b0;
      if (enabled) begin
         main_n_next = 1'b1;
         shed_n_next = !low_power_active;
         pg_next     = power_good_in;
         if (!crowbar_reg) begin
            pwm_next = low_power_active ? (pwm_in & lp_mask) : pwm_in;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwm_reg    <= '0;
         shed_n_reg <= 1'b0;
         main_n_reg <= 1'b0;
         pg_reg     <= 1'b0;
      end else begin
         pwm_reg    <= pwm_next;
         shed_n_reg <= shed_n_next;
         main_n_reg <= main_n_next;
         pg_reg     <= pg_next;
      end
   end

   assign pwm_out              = pwm_reg;
   assign shed_phase_disable_n = shed_n_reg;
   assign main_phase_disable_n = main_n_reg;
   assign power_good           = pg_reg;
   assign status_byte          = {2'b00, ot_warn_reg, ot_fault_reg, crowbar_reg, low_power_active,
                                  startup_begin, enabled};
endmodule

/* sim/psm_top_asserts.sv */
// Port timing checker of the phase shedding monitor
`timescale 1ns/1ps
module psm_top_asserts #(
   parameter int PHASES = 6
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              undervoltage_lockout,
   input wire logic              enable_above_threshold,
   input wire logic              low_power_state_input_n,
   input wire logic [11:0]       vout_mv,
   input wire logic [11:0]       vid_mv,
   input wire logic              reg_rd_en,
   input wire logic              reg_wr_en,
   input wire logic              reg_rd_valid,
   input wire logic [PHASES-1:0] pwm_out,
   input wire logic [PHASES-1:0] low_power_phase_mask,
   input wire logic              shed_phase_disable_n,
   input wire logic              main_phase_disable_n,
   input wire logic              power_good,
   input wire logic              startup_begin,
   input wire logic              crowbar_active
);
   // ************************************************************
   // Sequences and properties
   // ************************************************************
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_off;
      (undervoltage_lockout || !enable_above_threshold)[*7];
   endsequence
   sequence s_low;
      (!low_power_state_input_n)[*6];
   endsequence
   property p_off;
      s_off |-> pwm_out == '0 && !power_good && !shed_phase_disable_n && !main_phase_disable_n;
   endproperty
   property p_low;
      s_low |-> !shed_phase_disable_n;
   endproperty
   property p_mask;
      low_power_phase_mask[0] && !low_power_phase_mask[1] && !low_power_phase_mask[5];
   endproperty
   property p_cb_pwm;
      crowbar_active |=> pwm_out == '0;
   endproperty
   property p_cb_trip;
      $rose(crowbar_active) |-> {1'b0, $past(vout_mv)} > {1'b0, $past(vid_mv)} + 13'h096;
   endproperty
   property p_cb_rel;
      $fell(crowbar_active) |-> $past(vout_mv) < 12'h12c;
   endproperty
   property p_rd;
      reg_rd_en && !reg_wr_en |=> reg_rd_valid;
   endproperty
   property p_start;
      $rose(main_phase_disable_n) |-> $past(startup_begin);
   endproperty
   a_off: assert property (p_off) else $error("outputs on while disabled");
   a_low: assert property (p_low) else $error("shed disable high in low power");
   a_mask: assert property (p_mask) else $error("bad low power mask");
   a_cb_pwm: assert property (p_cb_pwm) else $error("pwm on during crowbar");
   a_cb_trip: assert property (p_cb_trip) else $error("crowbar below level");
   a_cb_rel: assert property (p_cb_rel) else $error("crowbar early release");
   a_rd: assert property (p_rd) else $error("read not answered");
   a_start: assert property (p_start) else $error("drivers on without start");
endmodule
bind psm_top psm_top_asserts #(.PHASES(PHASES)) u_chk (.*);

/* sim/psm_partner.sv */
// Load power state source and gate driver model
`timescale 1ns/1ps
module psm_partner (
   input wire logic        clk,
   input wire logic        lp_req,
   input wire logic [5:0]  pwm_out,
   input wire logic [5:0]  mask,
   input wire logic        shed_n,
   input wire logic        main_n,
   output logic            low_power_state_input_n,
   output logic [5:0]      driven
);
   // Load signals low power by pulling its pin low
   initial low_power_state_input_n = 1'b1;
   always @(negedge clk) begin
      low_power_state_input_n <= !lp_req;
   end
   // Drivers switch only while their disable input is high
   assign driven = main_n ? (pwm_out & (shed_n ? 6'h3f : mask)) : 6'h00;
endmodule

/* sim/test_phase_shedding_protection_monitor.sv */
// Self-checking testbench of the phase shedding monitor
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", \
   $time, g, e); end end
module test_phase_shedding_protection_monitor;
   import psm_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, lp_req = 1'b0, low_power_state_input_n, power_good_in = 1'b1;
   logic        enable_above_threshold = 1'b0, undervoltage_lockout = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic        reg_rd_valid, reg_cmd_error, power_good, shed_phase_disable_n, main_phase_disable_n;
   logic        startup_begin, crowbar_active, overtemp_indicator, overtemp_warning;
   logic [2:0]  normal_phase_count = 3'h6;
   logic [5:0]  pwm_in = 6'h3f, pwm_out, low_power_phase_mask, driven;
   logic [11:0] vout_mv = 12'h3e8, vid_mv = 12'h3e8;
   logic [9:0]  thermistor_sense_code = 10'h064, enable_pin_code = 10'h155;
   logic [9:0]  voltage_sense_one_code = 10'h3ff, voltage_sense_two_code = 10'h2aa;
   logic [7:0]  reg_cmd = 8'h00, reg_wdata = 8'h00;
   logic [15:0] reg_rdata;
   int          error_cnt = 0, comparisons = 0, starts = 0;
   // Clock and units
   always #5 clk = ~clk;
   // Count startup pulses seen mid-cycle
   always @(negedge clk) if (startup_begin) starts++;
   psm_top #(.PHASES(6), .ADC_BITS(10)) uut (.*);
   psm_partner u_far (.clk(clk), .lp_req(lp_req), .pwm_out(pwm_out), .mask(low_power_phase_mask),
      .shed_n(shed_phase_disable_n), .main_n(main_phase_disable_n),
      .low_power_state_input_n(low_power_state_input_n), .driven(driven));
   // Register port tasks and helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic er);
      reg_cmd = c;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
      `CHK(reg_cmd_error, er)
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic er);
      reg_cmd = c;
      reg_rd_en = 1'b1;
      @(negedge clk);
      reg_rd_en = 1'b0;
      `CHK({reg_rd_valid, reg_cmd_error, reg_rdata}, {1'b1, er, e})
      @(negedge clk);
   endtask
   task automatic cb(input logic [11:0] v, input logic e);
      vout_mv = v;
      cyc(3);
      `CHK({crowbar_active, crowbar_active ? pwm_out : 6'h00}, {e, 6'h00})
   endtask
   function automatic logic [5:0] lp_map(input int n, input int c);
      if (n == 6 && c == 2) return 6'h15;
      if (n >= 5 && c == 1) return 6'h09;
      if (n == 4 && c == 1) return 6'h05;
      return 6'h01;
   endfunction
   task automatic finish_test;
      if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      rd(CMD_MANUFACTURER_CONFIG, 16'h0000, 1'b0);
      rd(CMD_OVERTEMP_FAULT_LIMIT, 16'h00ff, 1'b0);
      rd(8'h00, 16'h0000, 1'b1);
      wr(CMD_READ_INPUT_VOLTAGE, 8'h12, 1'b1);
      for (int n = 1; n <= 6; n++) begin
         normal_phase_count = 3'(n);
         for (int c = 0; c < 4; c++) begin
            wr(CMD_MANUFACTURER_CONFIG, 8'(c << 6), 1'b0);
            `CHK(low_power_phase_mask, lp_map(n, c))
         end
      end
      rd(CMD_MANUFACTURER_CONFIG, 16'h00c0, 1'b0);
      wr(CMD_MANUFACTURER_CONFIG, 8'h00, 1'b0);
      undervoltage_lockout = 1'b0;
      cyc(8);
      `CHK({main_phase_disable_n, power_good, pwm_out}, 8'h00)
      enable_above_threshold = 1'b1;
      cyc(10);
      `CHK({main_phase_disable_n, shed_phase_disable_n, power_good, pwm_out}, 9'h1ff)
      lp_req = 1'b1;
      cyc(8);
      `CHK({main_phase_disable_n, shed_phase_disable_n, driven}, 8'h81)
      lp_req = 1'b0;
      undervoltage_lockout = 1'b1;
      cyc(8);
      `CHK({main_phase_disable_n, shed_phase_disable_n, power_good, pwm_out}, 9'h000)
      undervoltage_lockout = 1'b0;
      cyc(10);
      cb(12'h514, 1'b0);
      cb(12'h515, 1'b1);
      cb(12'h12c, 1'b1);
      cb(12'h12b, 1'b0);
      wr(CMD_POWER_GOOD_LIMITS, 8'h03, 1'b0);
      cb(12'h47e, 1'b0);
      cb(12'h47f, 1'b1);
      cb(12'h12b, 1'b0);
      wr(CMD_OVERTEMP_FAULT_LIMIT, 8'h64, 1'b0);
      wr(CMD_OVERTEMP_WARN_LIMIT, 8'h10, 1'b0);
      cyc(3);
      `CHK({overtemp_indicator, overtemp_warning}, 2'b01)
      rd(CMD_READ_TEMPERATURE, 16'h0064, 1'b0);
      thermistor_sense_code = 10'h065;
      cyc(3);
      `CHK(overtemp_indicator, 1'b1)
      wr(CMD_THERMISTOR_GAIN, 8'h03, 1'b0);
      wr(CMD_THERMISTOR_OFFSET, 8'h05, 1'b0);
      cyc(3);
      rd(CMD_READ_TEMPERATURE, 16'h0134, 1'b0);
      rd(CMD_READ_INPUT_VOLTAGE, 16'h1ff8, 1'b0);
      rd(CMD_READ_ENABLE_VOLTAGE, 16'h0155, 1'b0);
      rd(CMD_READ_SENSE_TWO, 16'h02aa, 1'b0);
      rd(CMD_POWER_GOOD_LIMITS, 16'h0003, 1'b0);
      rd(CMD_READ_STATUS, 16'h0031, 1'b0);
      `CHK(starts, 2)
      finish_test();
   end
   // Watchdog against a hung run
   initial begin
      #100000;
      error_cnt++;
      finish_test();
   end
endmodule
